// File: rtl/atsi_hold_xfer.sv
// holding register with busy handshake into the timer tick domain
`timescale 1ns/1ps
module atsi_hold_xfer #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk_sys_in,
   input  wire logic         rst_in,
   // write side
   input  wire logic         wr_in,
   input  wire logic [W-1:0] wdata_in,
   input  wire logic         async_in,
   input  wire logic         osc_edge_in,
   // transfer side
   output logic      [W-1:0] hold_out,
   output logic              busy_out,
   output logic              load_out
);
   logic [1:0] edge_cnt_reg;

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         hold_out <= '0;
      else if (wr_in)
         hold_out <= wdata_in;
   end

   // busy is the request, the second oscillator edge the acknowledge
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         busy_out     <= 1'b0;
         load_out     <= 1'b0;
         edge_cnt_reg <= 2'b00;
      end
      else if (wr_in)
      begin
         busy_out     <= async_in;
         load_out     <= !async_in;
         edge_cnt_reg <= 2'b00;
      end
      else if (busy_out && osc_edge_in)
      begin
         load_out <= 1'b0;
         if (edge_cnt_reg == 2'(atsi_pkg::XFER_EDGES - 1))
         begin
            busy_out <= 1'b0;
            load_out <= 1'b1;
         end
         edge_cnt_reg <= edge_cnt_reg + 2'b01;
      end
      else
         load_out <= 1'b0;
   end

   property p_xfer_edge;
      @(posedge clk_sys_in) disable iff (rst_in)
      $fell(busy_out) && !$past(wr_in) |-> load_out && $past(osc_edge_in);
   endproperty
   a_xfer_edge: assert property (p_xfer_edge)
      else $error("busy cleared without oscillator edge");
endmodule // atsi_hold_xfer

// File: rtl/atsi_pkg.sv
// constants for the asynchronous timer register transfer and interrupt block
package atsi_pkg;
   localparam logic [7:0] ADDR_COUNT    = 8'h00;
   localparam logic [7:0] ADDR_COMPARE  = 8'h04;
   localparam logic [7:0] ADDR_CTRL     = 8'h08;
   localparam logic [7:0] ADDR_STATUS   = 8'h0c;
   localparam logic [7:0] ADDR_MASK     = 8'h10;
   localparam logic [7:0] ADDR_FLAGS    = 8'h14;
   localparam logic [7:0] ADDR_SFIO     = 8'h18;
   // status fields
   localparam int BIT_ASYNC_SEL   = 3;
   localparam int BIT_COUNT_BUSY  = 2;
   localparam int BIT_CMP_BUSY    = 1;
   localparam int BIT_CTRL_BUSY   = 0;
   // mask, flag and sfio fields
   localparam int BIT_CMP_IRQ     = 7;
   localparam int BIT_OVF_IRQ     = 6;
   localparam int BIT_PSR         = 1;
   // control fields
   localparam int BIT_FORCE       = 7;
   localparam int BIT_WGM0        = 6;
   localparam int BIT_WGM1        = 3;
   localparam int COM_HI          = 5;
   localparam int COM_LO          = 4;
   localparam int CS_HI           = 2;
   localparam logic [7:0] MASK_RESET  = 8'h00;
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   // timing counts
   localparam int XFER_EDGES      = 2;
   localparam int FLAG_SYNC_CYC   = 3;
   localparam int CPU_HOLD_CYC    = 4;
   localparam int PRESC_W         = 10;
   typedef enum logic [1:0] {
      ATSI_NORMAL = 2'b00,
      ATSI_PC_PWM = 2'b01,
      ATSI_CTC    = 2'b10,
      ATSI_FAST   = 2'b11
   } atsi_wgm_t;
endpackage

// File: rtl/atsi_timer.sv
// asynchronous timer with register transfer, flags and wake-up
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module atsi_timer (
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // oscillator pin and core status
   input  wire logic        osc_in_pin_in,
   input  wire logic        global_irq_enable_in,
   input  wire logic        compare_vector_ack_in,
   input  wire logic        overflow_vector_ack_in,
   input  wire logic        sleeping_in,
   input  wire logic        deep_sleep_in,
   // outputs
   output logic             compare_irq_out,
   output logic             overflow_irq_out,
   output logic             wake_out,
   output logic             cpu_hold_out,
   output logic             osc_enable_out,
   output logic             osc_pins_detached_out,
   output logic             compare_output_pin_out
);
   logic       osc_s1_reg, osc_s2_reg, osc_s3_reg, osc_lvl_reg;
   logic       osc_edge_reg;
   logic       async_sel_reg;
   logic [7:0] irq_mask_reg;
   logic       cmp_flag_reg, ovf_flag_reg;
   logic       psr_reg;
   logic [atsi_pkg::PRESC_W-1:0] presc_reg;
   logic [7:0] count_reg, readback_reg, compare_reg, ctrl_reg;
   logic       down_reg;
   logic [2:0] cmp_pipe_reg, ovf_pipe_reg;
   logic       armed_reg;
   logic [2:0] hold_cnt_reg;
   logic       match_ev_reg;
   logic       tclk_en, count_tick, match, blk;
   logic       setup, wr_acc;
   logic       wr_count, wr_cmp, wr_ctrl;
   logic [7:0] h_count, h_cmp, h_ctrl;
   logic       b_count, b_cmp, b_ctrl;
   logic       ld_count, ld_cmp, ld_ctrl;
   logic       cmp_ev, ovf_ev, cmp_set, ovf_set;
   logic [7:0] count_next;
   logic       down_next, ovf_next;
   atsi_pkg::atsi_wgm_t wgm;

   // tick of the selected prescaler tap
   function automatic logic presc_tap(input logic [2:0] cs,
                                      input logic [9:0] p);
      logic [9:0] m;
      m = 10'h000;
      unique case (cs)
         3'h0: m = 10'h3ff;
         3'h1: m = 10'h000;
         3'h2: m = 10'h007;
         3'h3: m = 10'h01f;
         3'h4: m = 10'h03f;
         3'h5: m = 10'h07f;
         3'h6: m = 10'h0ff;
         3'h7: m = 10'h3ff;
      endcase
      return (cs != 3'h0) && ((p & m) == m);
   endfunction

   // oscillator pin synchroniser, edge once stages two and three agree
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         osc_s1_reg   <= 1'b0;
         osc_s2_reg   <= 1'b0;
         osc_s3_reg   <= 1'b0;
         osc_lvl_reg  <= 1'b0;
         osc_edge_reg <= 1'b0;
      end
      else
      begin
         osc_s1_reg   <= osc_in_pin_in;
         osc_s2_reg   <= osc_s1_reg;
         osc_s3_reg   <= osc_s2_reg;
         if (osc_s2_reg == osc_s3_reg)
            osc_lvl_reg <= osc_s3_reg;
         osc_edge_reg <= osc_s2_reg && osc_s3_reg && !osc_lvl_reg;
      end
   end

   // timer source: io clock unless the oscillator is selected
   assign tclk_en    = async_sel_reg ? osc_edge_reg : 1'b1;
   assign wgm        = atsi_pkg::atsi_wgm_t'({ctrl_reg[atsi_pkg::BIT_WGM1],
                                   ctrl_reg[atsi_pkg::BIT_WGM0]});
   assign count_tick = tclk_en && !psr_reg
                       && presc_tap(ctrl_reg[atsi_pkg::CS_HI:0], presc_reg);

   // apb decode
   assign setup    = psel_in && !penable_in;
   assign wr_acc   = psel_in && penable_in && pready_out && pwrite_in;
   assign wr_count = wr_acc && paddr_in == atsi_pkg::ADDR_COUNT;
   assign wr_cmp   = wr_acc && paddr_in == atsi_pkg::ADDR_COMPARE;
   assign wr_ctrl  = wr_acc && paddr_in == atsi_pkg::ADDR_CTRL;

   atsi_hold_xfer #(.W(8)) u_count (
      .clk_sys_in  (clk_sys_in),
      .rst_in      (rst_in),
      .wr_in       (wr_count),
      .wdata_in    (pwdata_in[7:0]),
      .async_in    (async_sel_reg),
      .osc_edge_in (osc_edge_reg),
      .hold_out    (h_count),
      .busy_out    (b_count),
      .load_out    (ld_count)
   );
   atsi_hold_xfer #(.W(8)) u_cmp (
      .clk_sys_in  (clk_sys_in),
      .rst_in      (rst_in),
      .wr_in       (wr_cmp),
      .wdata_in    (pwdata_in[7:0]),
      .async_in    (async_sel_reg),
      .osc_edge_in (osc_edge_reg),
      .hold_out    (h_cmp),
      .busy_out    (b_cmp),
      .load_out    (ld_cmp)
   );
   // the force strobe is not stored, so it reads back as zero
   atsi_hold_xfer #(.W(8)) u_ctrl (
      .clk_sys_in  (clk_sys_in),
      .rst_in      (rst_in),
      .wr_in       (wr_ctrl),
      .wdata_in    ({1'b0, pwdata_in[6:0]}),
      .async_in    (async_sel_reg),
      .osc_edge_in (osc_edge_reg),
      .hold_out    (h_ctrl),
      .busy_out    (b_ctrl),
      .load_out    (ld_ctrl)
   );

   // apb answer: data and ready prepared in the setup cycle
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         prdata_out  <= 32'h0000_0000;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end
      else
      begin
         pready_out  <= setup;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
         if (setup)
         begin
            unique case (paddr_in)
               atsi_pkg::ADDR_COUNT:   prdata_out[7:0] <= readback_reg;
               atsi_pkg::ADDR_COMPARE: prdata_out[7:0] <= h_cmp;
               atsi_pkg::ADDR_CTRL:    prdata_out[7:0] <= h_ctrl;
               atsi_pkg::ADDR_STATUS:  prdata_out[3:0] <=
                  {async_sel_reg, b_count, b_cmp, b_ctrl};
               atsi_pkg::ADDR_MASK:    prdata_out[7:0] <= irq_mask_reg;
               atsi_pkg::ADDR_FLAGS:   prdata_out[7:6] <=
                  {cmp_flag_reg, ovf_flag_reg};
               atsi_pkg::ADDR_SFIO:    prdata_out[atsi_pkg::BIT_PSR] <=
                  psr_reg && async_sel_reg;
               default:                pslverr_out <= 1'b1;
            endcase
         end
      end
   end

   // software control bits
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         async_sel_reg <= 1'b0;
         irq_mask_reg  <= atsi_pkg::MASK_RESET;
      end
      else if (wr_acc && paddr_in == atsi_pkg::ADDR_STATUS)
         async_sel_reg <= pwdata_in[atsi_pkg::BIT_ASYNC_SEL];
      else if (wr_acc && paddr_in == atsi_pkg::ADDR_MASK)
         irq_mask_reg  <= {pwdata_in[7:6], 6'h00};
   end

   // prescaler with reset request held until a timer tick takes it
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         psr_reg   <= 1'b0;
         presc_reg <= '0;
      end
      else
      begin
         if (wr_acc && paddr_in == atsi_pkg::ADDR_SFIO
             && pwdata_in[atsi_pkg::BIT_PSR])
            psr_reg <= 1'b1;
         else if (tclk_en)
            psr_reg <= 1'b0;
         if (tclk_en)
            presc_reg <= psr_reg ? '0 : presc_reg + 1'b1;
      end
   end

   // counter sequencing per waveform mode
   assign blk   = b_count || b_cmp || ld_count || ld_cmp;
   assign match = (count_reg == compare_reg) && !blk;
   always_comb
   begin
      count_next = count_reg + 8'h01;
      down_next  = down_reg;
      ovf_next   = 1'b0;
      unique case (wgm)
         atsi_pkg::ATSI_NORMAL, atsi_pkg::ATSI_FAST:
            ovf_next = count_reg == 8'hff;
         atsi_pkg::ATSI_CTC:
         begin
            ovf_next = count_reg == 8'hff;
            if (match)
               count_next = 8'h00;
         end
         atsi_pkg::ATSI_PC_PWM:
         begin
            if (!down_reg && count_reg == 8'hff)
            begin
               down_next  = 1'b1;
               count_next = count_reg - 8'h01;
            end
            else if (down_reg && count_reg == 8'h00)
            begin
               down_next  = 1'b0;
               ovf_next   = 1'b1;
            end
            else if (down_reg)
               count_next = count_reg - 8'h01;
         end
      endcase
   end

   // destinations load from holding registers, a load beats a tick
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         count_reg    <= 8'h00;
         compare_reg  <= 8'h00;
         ctrl_reg     <= atsi_pkg::CTRL_RESET;
         down_reg     <= 1'b0;
         match_ev_reg <= 1'b0;
      end
      else
      begin
         match_ev_reg <= 1'b0;
         if (ld_cmp)
            compare_reg <= h_cmp;
         if (ld_ctrl)
            ctrl_reg <= h_ctrl;
         if (ld_count)
            count_reg <= h_count;
         else if (count_tick)
         begin
            count_reg    <= count_next;
            down_reg     <= down_next;
            match_ev_reg <= match;
         end
      end
   end

   // compare pin follows the timer tick, not the processor clock
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         compare_output_pin_out <= 1'b0;
      else if (count_tick && !ld_count)
      begin
         if (wgm == atsi_pkg::ATSI_NORMAL || wgm == atsi_pkg::ATSI_CTC)
         begin
            if (match)
               unique case (ctrl_reg[atsi_pkg::COM_HI:atsi_pkg::COM_LO])
                  2'h0: compare_output_pin_out <= 1'b0;
                  2'h1: compare_output_pin_out <= !compare_output_pin_out;
                  2'h2: compare_output_pin_out <= 1'b0;
                  2'h3: compare_output_pin_out <= 1'b1;
               endcase
         end
         else if (ctrl_reg[atsi_pkg::COM_HI])
         begin
            if (match)
               compare_output_pin_out <= ctrl_reg[atsi_pkg::COM_LO]
                  ^ (wgm == atsi_pkg::ATSI_PC_PWM && down_reg);
            else if (wgm == atsi_pkg::ATSI_FAST && count_reg == 8'hff)
               compare_output_pin_out <= !ctrl_reg[atsi_pkg::COM_LO];
         end
      end
   end

   // flag events cross with three processor cycles when asynchronous
   assign cmp_ev  = match_ev_reg;
   assign ovf_ev  = count_tick && !ld_count && ovf_next;
   assign cmp_set = async_sel_reg ? cmp_pipe_reg[2] : cmp_ev;
   assign ovf_set = async_sel_reg ? ovf_pipe_reg[2] : ovf_ev;
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         cmp_pipe_reg <= 3'h0;
         ovf_pipe_reg <= 3'h0;
      end
      else
      begin
         cmp_pipe_reg <= {cmp_pipe_reg[1:0], cmp_ev && async_sel_reg};
         ovf_pipe_reg <= {ovf_pipe_reg[1:0], ovf_ev && async_sel_reg};
      end
   end

   // sticky flags, a set in the clearing cycle wins
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         cmp_flag_reg <= 1'b0;
         ovf_flag_reg <= 1'b0;
      end
      else
      begin
         if (cmp_set)
            cmp_flag_reg <= 1'b1;
         else if (compare_vector_ack_in || (wr_acc
                  && paddr_in == atsi_pkg::ADDR_FLAGS
                  && pwdata_in[atsi_pkg::BIT_CMP_IRQ]))
            cmp_flag_reg <= 1'b0;
         if (ovf_set)
            ovf_flag_reg <= 1'b1;
         else if (overflow_vector_ack_in || (wr_acc
                  && paddr_in == atsi_pkg::ADDR_FLAGS
                  && pwdata_in[atsi_pkg::BIT_OVF_IRQ]))
            ovf_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         compare_irq_out  <= 1'b0;
         overflow_irq_out <= 1'b0;
      end
      else
      begin
         compare_irq_out  <= irq_mask_reg[atsi_pkg::BIT_CMP_IRQ]
                             && global_irq_enable_in && cmp_flag_reg;
         overflow_irq_out <= irq_mask_reg[atsi_pkg::BIT_OVF_IRQ]
                             && global_irq_enable_in && ovf_flag_reg;
      end
   end

   // oscillator power and pin ownership; deep sleep stops the oscillator, pins stay detached
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         osc_enable_out        <= 1'b0;
         osc_pins_detached_out <= 1'b0;
      end
      else
      begin
         osc_enable_out        <= async_sel_reg && !deep_sleep_in;
         osc_pins_detached_out <= async_sel_reg;
      end
   end

   // wake on the tick after the condition; rearm after one tick awake
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         wake_out     <= 1'b0;
         armed_reg    <= 1'b1;
         cpu_hold_out <= 1'b0;
         hold_cnt_reg <= 3'h0;
      end
      else
      begin
         if (!sleeping_in)
            wake_out <= 1'b0;
         else if (tclk_en && armed_reg && (compare_irq_out
                  || overflow_irq_out))
         begin
            wake_out  <= 1'b1;
            armed_reg <= 1'b0;
         end
         if (!armed_reg && !sleeping_in && tclk_en)
            armed_reg <= 1'b1;
         if (wake_out && !sleeping_in && !cpu_hold_out
             && hold_cnt_reg == 3'h0)
         begin
            cpu_hold_out <= 1'b1;
            hold_cnt_reg <= 3'(atsi_pkg::CPU_HOLD_CYC - 1);
         end
         else if (hold_cnt_reg != 3'h0)
            hold_cnt_reg <= hold_cnt_reg - 3'h1;
         else
            cpu_hold_out <= 1'b0;
      end
   end

   // readback refreshed on every timer tick edge
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         readback_reg <= 8'h00;
      else if (tclk_en)
         readback_reg <= count_reg;
   end

   property p_busy_ctrl;
      @(posedge clk_sys_in) disable iff (rst_in)
      wr_ctrl && async_sel_reg |=> b_ctrl;
   endproperty
   a_busy_ctrl: assert property (p_busy_ctrl)
      else $error("control busy not set by write");

   property p_busy_cnt;
      @(posedge clk_sys_in) disable iff (rst_in)
      (wr_count && async_sel_reg |=> b_count)
      and (wr_cmp && async_sel_reg |=> b_cmp);
   endproperty
   a_busy_cnt: assert property (p_busy_cnt)
      else $error("count or compare busy not set");

   property p_read_cmp;
      @(posedge clk_sys_in) disable iff (rst_in)
      setup && paddr_in == atsi_pkg::ADDR_COMPARE
      |=> prdata_out[7:0] == $past(h_cmp) && pready_out;
   endproperty
   a_read_cmp: assert property (p_read_cmp)
      else $error("compare read not from holding register");

   property p_no_match;
      @(posedge clk_sys_in) disable iff (rst_in)
      b_cmp || b_count |=> !match_ev_reg;
   endproperty
   a_no_match: assert property (p_no_match)
      else $error("compare match during transfer");

   property p_irq_cmp;
      @(posedge clk_sys_in) disable iff (rst_in)
      ##1 compare_irq_out == $past(cmp_flag_reg && global_irq_enable_in
                           && irq_mask_reg[atsi_pkg::BIT_CMP_IRQ]);
   endproperty
   a_irq_cmp: assert property (p_irq_cmp)
      else $error("compare interrupt mismatch");

   property p_irq_ovf;
      @(posedge clk_sys_in) disable iff (rst_in)
      overflow_irq_out |-> $past(ovf_flag_reg && global_irq_enable_in);
   endproperty
   a_irq_ovf: assert property (p_irq_ovf)
      else $error("overflow interrupt without cause");

   property p_flag_sync;
      @(posedge clk_sys_in) disable iff (rst_in)
      cmp_ev && async_sel_reg ##1 async_sel_reg [*3] |=> cmp_flag_reg;
   endproperty
   a_flag_sync: assert property (p_flag_sync)
      else $error("compare flag not set three cycles after event");

   property p_psr_clear;
      @(posedge clk_sys_in) disable iff (rst_in)
      psr_reg && tclk_en && !wr_acc |=> !psr_reg && presc_reg == '0;
   endproperty
   a_psr_clear: assert property (p_psr_clear)
      else $error("prescaler reset not completed");

   property p_hold4;
      @(posedge clk_sys_in) disable iff (rst_in)
      $rose(cpu_hold_out) |-> cpu_hold_out [*4] ##1 !cpu_hold_out;
   endproperty
   a_hold4: assert property (p_hold4)
      else $error("processor hold not four cycles");

   c_async_xfer: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      $fell(b_cmp));
   c_cmp_irq: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      $rose(compare_irq_out));
   c_wake: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      $rose(wake_out));
endmodule // atsi_timer

// File: verif/atsi_xtal_model.sv
// behavioural watch crystal driving the oscillator pin
`timescale 1ns/1ps
module atsi_xtal_model #(
   parameter int HALF_NS = 200
) (
   // oscillator enable from the block
   input  wire logic en_in,
   // oscillator pin
   output logic      osc_out
);
   // crystal stands still and low while stopped, as in deep sleep
   initial
   begin
      osc_out = 1'b0;
      forever
      begin
         #(HALF_NS);
         osc_out = en_in ? ~osc_out : 1'b0;
      end
   end
endmodule // atsi_xtal_model

// File: verif/testbench.sv
// self-checking bench for the asynchronous timer block
`timescale 1ns/1ps
module testbench;
   logic        clk_sys_in;
   logic        rst_in;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic        gie;
   logic        dsl;
   logic        slv;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [31:0] r;
   logic        pready;
   logic        pslverr;
   logic        osc;
   logic        osc_en;
   logic        det;
   logic        cirq;
   logic        oirq;
   logic        slp;
   logic        cack;
   logic        wake;
   logic        hold;
   logic        pin;
   int          err_total;
   int          samples_checked;

   atsi_timer dut (
      .clk_sys_in             (clk_sys_in),
      .rst_in                 (rst_in),
      .psel_in                (psel),
      .penable_in             (penable),
      .pwrite_in              (pwrite),
      .paddr_in               (paddr),
      .pwdata_in              (pwdata),
      .prdata_out             (prdata),
      .pready_out             (pready),
      .pslverr_out            (pslverr),
      .osc_in_pin_in          (osc),
      .global_irq_enable_in   (gie),
      .compare_vector_ack_in  (cack),
      .overflow_vector_ack_in (1'b0),
      .sleeping_in            (slp),
      .deep_sleep_in          (dsl),
      .compare_irq_out        (cirq),
      .overflow_irq_out       (oirq),
      .wake_out               (wake),
      .cpu_hold_out           (hold),
      .osc_enable_out         (osc_en),
      .osc_pins_detached_out  (det),
      .compare_output_pin_out (pin)
   );

   atsi_xtal_model xtal (
      .en_in   (osc_en),
      .osc_out (osc)
   );

   initial
   begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // apb transfer; answer is taken at the edge where pready is high
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      do
         @(posedge clk_sys_in);
      while (pready !== 1'b1);
      r   = prdata;
      slv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   initial
   begin
      repeat (6000) @(posedge clk_sys_in);
      err_total++;
      tally_and_finish();
   end

   initial
   begin
      {psel, penable, pwrite, gie, dsl, slp, cack} = 7'h00;
      paddr  = 8'h00;
      pwdata = 32'h0;
      rst_in = 1'b1;
      repeat (20) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      bus(1'b0, atsi_pkg::ADDR_MASK, 32'h0);
      chk(r, 32'h0);
      bus(1'b0, atsi_pkg::ADDR_STATUS, 32'h0);
      chk(r, 32'h0);
      bus(1'b0, 8'h1c, 32'h0);
      chk({31'h0, slv}, 32'h1);
      $display("test reset done");
      bus(1'b1, atsi_pkg::ADDR_COMPARE, 32'h5a);
      bus(1'b0, atsi_pkg::ADDR_COMPARE, 32'h0);
      chk(r, 32'h5a);
      bus(1'b1, atsi_pkg::ADDR_SFIO, 32'h2);
      bus(1'b0, atsi_pkg::ADDR_SFIO, 32'h0);
      chk(r, 32'h0);
      $display("test sync access done");
      gie <= 1'b1;
      bus(1'b1, atsi_pkg::ADDR_MASK, 32'hc0);
      bus(1'b1, atsi_pkg::ADDR_COMPARE, 32'h10);
      bus(1'b1, atsi_pkg::ADDR_COUNT, 32'h0);
      bus(1'b1, atsi_pkg::ADDR_CTRL, 32'h31);
      // long enough for a match and a full 256-step wrap
      repeat (400) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk({30'h0, cirq, oirq}, 32'h3);
      chk({31'h0, pin}, 32'h1);
      @(posedge clk_sys_in);
      slp <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk({31'h0, wake}, 32'h1);
      @(posedge clk_sys_in);
      slp <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk({30'h0, wake, hold}, 32'h1);
      repeat (4) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk({30'h0, wake, hold}, 32'h0);
      @(posedge clk_sys_in);
      cack <= 1'b1;
      @(posedge clk_sys_in);
      cack <= 1'b0;
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      // vector ack clears only the compare flag, well before the next match
      chk({30'h0, cirq, oirq}, 32'h1);
      @(posedge clk_sys_in);
      gie <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk({30'h0, cirq, oirq}, 32'h0);
      bus(1'b1, atsi_pkg::ADDR_CTRL, 32'h0);
      bus(1'b0, atsi_pkg::ADDR_FLAGS, 32'h0);
      chk(r & 32'hc0, 32'h40);
      bus(1'b1, atsi_pkg::ADDR_FLAGS, 32'hc0);
      bus(1'b0, atsi_pkg::ADDR_FLAGS, 32'h0);
      chk(r, 32'h0);
      $display("test flags done");
      bus(1'b1, atsi_pkg::ADDR_MASK, 32'h0);
      bus(1'b1, atsi_pkg::ADDR_STATUS, 32'h08);
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk({31'h0, det}, 32'h1);
      bus(1'b1, atsi_pkg::ADDR_CTRL, 32'h02);
      bus(1'b1, atsi_pkg::ADDR_COMPARE, 32'h33);
      bus(1'b1, atsi_pkg::ADDR_COUNT, 32'h07);
      bus(1'b0, atsi_pkg::ADDR_STATUS, 32'h0);
      chk(r, 32'h0f);
      bus(1'b0, atsi_pkg::ADDR_COMPARE, 32'h0);
      chk(r, 32'h33);
      repeat (60)
      begin
         bus(1'b0, atsi_pkg::ADDR_STATUS, 32'h0);
         if (r[2:0] === 3'b000)
            break;
      end
      chk(r, 32'h08);
      bus(1'b1, atsi_pkg::ADDR_FLAGS, 32'hc0);
      bus(1'b0, atsi_pkg::ADDR_CTRL, 32'h0);
      chk(r, 32'h02);
      dsl <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk({31'h0, osc_en}, 32'h0);
      @(posedge clk_sys_in);
      dsl <= 1'b0;
      $display("test async transfer done");
      tally_and_finish();
   end
endmodule // testbench
